// >>> hw/gear_edge_threshold.sv
`default_nettype none
// Overview of operation
// RULE_01: After reset the output is held high (OFF) before any edge; with reverse_dir_in high the code drives it low once calibration ends.
// RULE_02: Reference direction gives a low output while a tooth faces.
// RULE_03: Opposite rotation inverts the output polarity.
// RULE_04: The first edge may not toggle; the second always does.
// RULE_05: The first falling edge is detected without an extra cal edge.
// RULE_06: Under undervoltage the output is forced OFF and held there.
// RULE_07: After power-up span is measured and gain set for fixed span.
// RULE_08: Peak and valley trackers give the switching reference.
// RULE_09: Thresholds sit at 30% and 70% of the tracked span.
// RULE_10: Hysteresis between on and off thresholds is 40% of span.
// RULE_11: Hysteresis fraction is fixed whatever the air gap.
// RULE_12: Thresholds follow the tracked span, not fixed levels.
// RULE_13: Thresholds update each edge from the two preceding edges.
// RULE_14: Output goes low above the upper and high below the lower one.
// RULE_15: Samples are processed on one clock and cleared by reset.
module gear_edge_threshold
  import gear_edge_pkg::*;
#(
  parameter int unsigned CAL_CYC = gear_edge_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Signal input
  input wire logic signed [gear_edge_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  input wire logic reverse_dir_in,
  input wire logic supply_undervoltage_level_in,
  // Output
  output logic speed_out,
  output logic [gear_edge_pkg::GAIN_W-1:0] gain_out,
  output logic calibrated_out
);
  import gear_edge_pkg::*;
  localparam int unsigned W = SAMPLE_W;

  mode_t mode_q, mode_d;
  logic [15:0] cnt_q, cnt_d;
  logic [W-1:0] raw_max_q, raw_max_d, raw_min_q, raw_min_d;
  logic [GAIN_W-1:0] gain_q, gain_d;
  logic [W-1:0] norm;
  logic [W-1:0] pk_q, pk_d, vl_q, vl_d;
  logic on_q, on_d;
  logic [1:0] edges_q, edges_d;
  logic out_q, out_d;
  logic push;
  logic [W-1:0] hist_pk, hist_vl;
  logic [W-1:0] span, thr_hi, thr_lo;
  logic [W+GAIN_W-1:0] prod;
  logic [W-1:0] raw_span;
  logic [W+7:0] hi_prod, lo_prod;

  // Offset to unsigned, then scale by gain
  always_comb begin
    prod = {{GAIN_W{1'b0}}, sample_in ^ {1'b1, {(W-1){1'b0}}}} * gain_q;
    norm = (|prod[W+GAIN_W-1:W+GAIN_FRAC]) ? {W{1'b1}}
         : prod[W+GAIN_FRAC-1:GAIN_FRAC];
  end

  // Power-up calibration: measure span then fix gain
  always_comb begin
    mode_d = mode_q;
    cnt_d = cnt_q;
    raw_max_d = raw_max_q;
    raw_min_d = raw_min_q;
    gain_d = gain_q;
    raw_span = raw_max_q - raw_min_q;
    case (mode_q)
      ST_CAL: begin // see RULE_07
        if (sample_valid_in) begin
          if (norm > raw_max_q) raw_max_d = norm;
          if (norm < raw_min_q) raw_min_d = norm;
        end
        cnt_d = cnt_q + 16'h0001;
        if (32'(cnt_q) >= CAL_CYC - 1) mode_d = ST_GAIN;
      end
      ST_GAIN: begin // see RULE_07
        // Coarse divide keeps the logic small; span lands within 2x unless below 1/16 of target
        gain_d = GAIN_UNITY;
        if (raw_span != '0 && raw_span < TARGET_SPAN) begin
          for (int i = 1; i < 4; i++) begin
            // Widened so the shifted span cannot wrap to a small value
            if (({3'b000, raw_span} << i) <= {3'b000, TARGET_SPAN})
              gain_d = GAIN_W'(GAIN_UNITY << i);
          end
        end
        mode_d = ST_RUN;
      end
      ST_RUN: mode_d = ST_RUN;
      default: mode_d = ST_CAL;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin // see RULE_15
      mode_q <= ST_CAL;
      cnt_q <= 16'h0000;
      raw_max_q <= '0;
      raw_min_q <= '1;
      gain_q <= GAIN_UNITY;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      raw_max_q <= raw_max_d;
      raw_min_q <= raw_min_d;
      gain_q <= gain_d;
    end
  end

  // Thresholds from the two preceding edges' extremes
  always_comb begin
    span = hist_pk - hist_vl; // see RULE_12
    hi_prod = {8'h00, span} * 20'(THR_HI_PCT); // see RULE_09
    lo_prod = {8'h00, span} * 20'(THR_LO_PCT); // see RULE_10 RULE_11
    thr_hi = hist_vl + W'(hi_prod / 20'(PCT_SCALE));
    thr_lo = hist_vl + W'(lo_prod / 20'(PCT_SCALE));
  end

  // Current half-period extremes; pushed at each switching edge
  always_comb begin
    pk_d = pk_q;
    vl_d = vl_q;
    on_d = on_q;
    edges_d = edges_q;
    push = 1'b0;
    if (sample_valid_in) begin
      if (norm > pk_q) pk_d = norm; // see RULE_08
      if (norm < vl_q) vl_d = norm;
      // No switching in lockout, so the edge history stays intact
      if (mode_q == ST_RUN && !supply_undervoltage_level_in) begin
        // Until two edges are seen, thresholds come from calibration
        if (!on_q && norm > thr_hi) begin // see RULE_14 RULE_05
          on_d = 1'b1;
          push = 1'b1;
        end else if (on_q && norm < thr_lo) begin // see RULE_14
          on_d = 1'b0;
          push = 1'b1;
        end
      end
    end
    if (push) begin // see RULE_13
      pk_d = norm;
      vl_d = norm;
      if (edges_q != MIN_EDGES) edges_d = edges_q + 2'h1; // see RULE_04
    end
    if (supply_undervoltage_level_in) on_d = 1'b0; // see RULE_06
    // Reference direction: tooth high, so ON (low) tracks signal above
    out_d = !(on_d ^ reverse_dir_in); // see RULE_02 RULE_03
    if (supply_undervoltage_level_in || mode_q != ST_RUN)
      out_d = 1'b1; // see RULE_06 RULE_01
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pk_q <= '0;
      vl_q <= '1;
      on_q <= 1'b0;
      edges_q <= 2'h0;
      out_q <= 1'b1; // see RULE_01
    end else begin
      pk_q <= pk_d;
      vl_q <= vl_d;
      on_q <= on_d;
      edges_q <= edges_d;
      out_q <= out_d;
    end
  end

  edge_history #(.W(W)) u_hist (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(push || mode_q == ST_GAIN),
    .peak_in(mode_q == ST_GAIN ? raw_max_q : pk_q),
    .valley_in(mode_q == ST_GAIN ? raw_min_q : vl_q),
    .peak_out(hist_pk),
    .valley_out(hist_vl)
  );

  assign speed_out = out_q;
  assign gain_out = gain_q;
  assign calibrated_out = (mode_q == ST_RUN);

  a_por_off: assert property (@(posedge ref_clk_in) // see RULE_01
    $past(sys_rst_in) |-> speed_out == 1'b1)
    else $error("output not OFF after reset");

  a_uv_forced: assert property (@(posedge ref_clk_in) // see RULE_06
    disable iff (sys_rst_in)
    $past(supply_undervoltage_level_in) |-> speed_out == 1'b1)
    else $error("output not OFF in undervoltage");

  sequence s_rise_hi;
    sample_valid_in && mode_q == ST_RUN && !supply_undervoltage_level_in
      && !on_q && norm > thr_hi;
  endsequence
  a_switch_on: assert property (@(posedge ref_clk_in) // see RULE_14
    disable iff (sys_rst_in)
    s_rise_hi |=> on_q)
    else $error("missed upper threshold crossing");

  a_polarity: assert property (@(posedge ref_clk_in) // see RULE_03
    disable iff (sys_rst_in)
    mode_q == ST_RUN && $past(mode_q) == ST_RUN
      && !$past(supply_undervoltage_level_in)
    |-> speed_out == !($past(on_d) ^ $past(reverse_dir_in)))
    else $error("wrong output polarity");

  a_thr_order: assert property (@(posedge ref_clk_in) // see RULE_10
    disable iff (sys_rst_in) thr_lo <= thr_hi)
    else $error("threshold order broken");

  // Rounding of each threshold may shift the gap by one count
  a_hyst_span: assert property (@(posedge ref_clk_in) // see RULE_10
    disable iff (sys_rst_in)
    mode_q == ST_RUN |->
      20'(thr_hi - thr_lo) * 20'(PCT_SCALE) + 20'(PCT_SCALE)
        >= 20'(span) * 20'(HYST_PCT)
      && 20'(thr_hi - thr_lo) * 20'(PCT_SCALE)
        <= 20'(span) * 20'(HYST_PCT) + 20'(PCT_SCALE))
    else $error("hysteresis not 40 percent of span");

  // Second edge with steady supply and direction
  sequence s_second_edge;
    push && edges_q == 2'h1 && !supply_undervoltage_level_in
      && !$past(supply_undervoltage_level_in)
      && reverse_dir_in == $past(reverse_dir_in);
  endsequence
  a_second_edge: assert property (@(posedge ref_clk_in) // see RULE_04
    disable iff (sys_rst_in)
    s_second_edge |=> speed_out != $past(speed_out))
    else $error("second edge did not toggle output");

  a_cal_done: assert property (@(posedge ref_clk_in) // see RULE_07
    disable iff (sys_rst_in) mode_q == ST_GAIN |=> mode_q == ST_RUN)
    else $error("gain step did not finish");
endmodule : gear_edge_threshold
`default_nettype wire

// >>> hw/gear_edge_pkg.sv
`default_nettype none
package gear_edge_pkg;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned GAIN_W = 8;
  // Normalised span target after gain setting
  localparam logic [11:0] TARGET_SPAN = 12'h800;
  localparam logic [7:0] GAIN_UNITY = 8'h10;
  localparam int unsigned GAIN_FRAC = 4;
  localparam int unsigned THR_LO_PCT = 30;
  localparam int unsigned THR_HI_PCT = 70;
  localparam int unsigned HYST_PCT = 40;
  localparam int unsigned PCT_SCALE = 100;
  localparam logic [1:0] MIN_EDGES = 2'h2;
  // Calibration window in cycles (200 us at 25 MHz)
  localparam int unsigned CAL_TIME_US = 200;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ST_CAL = 2'b00,
    ST_GAIN = 2'b01,
    ST_RUN = 2'b11
  } mode_t;
endpackage : gear_edge_pkg
`default_nettype wire

// >>> hw/edge_history.sv
`default_nettype none
// Holds peak and valley of the last two half periods
module edge_history #(
  parameter int unsigned W = 12
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Update
  input wire logic push_in,
  input wire logic [W-1:0] peak_in,
  input wire logic [W-1:0] valley_in,
  // Read
  output logic [W-1:0] peak_out,
  output logic [W-1:0] valley_out
);
  logic [W-1:0] pk_q [2];
  logic [W-1:0] vl_q [2];
  logic [W-1:0] pk_d [2];
  logic [W-1:0] vl_d [2];
  logic [W-1:0] peak_q, valley_q, peak_d, valley_d;

  always_comb begin
    pk_d = pk_q;
    vl_d = vl_q;
    if (push_in) begin
      pk_d[1] = pk_q[0];
      vl_d[1] = vl_q[0];
      pk_d[0] = peak_in;
      vl_d[0] = valley_in;
    end
    // Larger peak and smaller valley of the two edges; taken from the
    // next values so the reference is ready right after a push
    peak_d = (pk_d[0] > pk_d[1]) ? pk_d[0] : pk_d[1];
    valley_d = (vl_d[0] < vl_d[1]) ? vl_d[0] : vl_d[1];
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pk_q[0] <= '0;
      pk_q[1] <= '0;
      // Empty valley slots must never win the minimum
      vl_q[0] <= '1;
      vl_q[1] <= '1;
      peak_q <= '0;
      valley_q <= '0;
    end else begin
      pk_q <= pk_d;
      vl_q <= vl_d;
      peak_q <= peak_d;
      valley_q <= valley_d;
    end
  end

  assign peak_out = peak_q;
  assign valley_out = valley_q;
endmodule : edge_history
`default_nettype wire

// >>> bench/speed_reader.sv
`default_nettype none
// Controller side: counts ON entries seen on the speed line
module speed_reader (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic speed_in,
  output logic [7:0] falls_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  always @(posedge ref_clk_in) begin
    last_q <= speed_in;
    if (rst_in) begin
      falls_out <= 8'h00;
    end else if (last_q === 1'b1 && speed_in === 1'b0) begin
      falls_out <= falls_out + 8'h01;
    end
  end
endmodule : speed_reader
`default_nettype wire

// >>> bench/tb_gear_edge_threshold.sv
`default_nettype none
module tb_gear_edge_threshold;
  timeunit 1ns;
  timeprecision 1ps;
  import gear_edge_pkg::*;
  localparam logic [11:0] HI = 12'h300;
  localparam logic [11:0] LO = 12'hd00;
  localparam logic [11:0] MID = 12'h000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic signed [11:0] smp = 12'h000;
  logic vld = 1'b0;
  logic rev = 1'b0;
  logic uv = 1'b0;
  logic spd;
  logic [7:0] gain;
  logic cal;
  logic [7:0] falls;
  int bad_count = 0;
  int num_checks = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  gear_edge_threshold #(.CAL_CYC(50)) dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .sample_in(smp),
    .sample_valid_in(vld), .reverse_dir_in(rev),
    .supply_undervoltage_level_in(uv), .speed_out(spd),
    .gain_out(gain), .calibrated_out(cal));
  speed_reader ctl (.ref_clk_in(clk), .rst_in(rst), .speed_in(spd),
    .falls_out(falls));
  task automatic chk(input string nm, input logic [7:0] e, got);
    num_checks++;
    if (got !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, got);
      bad_count++;
    end
  endtask : chk
  // Level is held a few cycles so the registered answer has settled
  task automatic drive(input logic [11:0] v, input int n);
    smp = v;
    repeat (n) @(negedge clk);
  endtask : drive
  task automatic results();
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic t_reset();
    repeat (10) @(negedge clk);
    chk("speed", 8'h01, {7'h00, spd});
    chk("gain", GAIN_UNITY, gain);
    chk("cal", 8'h00, {7'h00, cal});
    rst = 1'b0;
    vld = 1'b1;
  endtask : t_reset
  task automatic t_calib();
    int k;
    for (k = 0; k < 6; k++) begin
      drive(k[0] ? LO : HI, 10);
      chk("cal speed", 8'h01, {7'h00, spd});
    end
    k = 0;
    while (cal !== 1'b1 && k < 100) begin
      drive(LO, 1);
      k++;
    end
    chk("cal", 8'h01, {7'h00, cal});
    // Span 0x600 leaves no room to double
    chk("gain", 8'h10, gain);
  endtask : t_calib
  task automatic t_switch();
    vld = 1'b0;
    drive(HI, 3);
    chk("no sample", 8'h01, {7'h00, spd});
    vld = 1'b1;
    drive(HI, 4);
    chk("on", 8'h00, {7'h00, spd});
    drive(MID, 4);
    chk("hold on", 8'h00, {7'h00, spd});
    drive(LO, 4);
    chk("off", 8'h01, {7'h00, spd});
    drive(MID, 4);
    chk("hold off", 8'h01, {7'h00, spd});
    drive(HI, 4);
    chk("on again", 8'h00, {7'h00, spd});
  endtask : t_switch
  task automatic t_uv();
    uv = 1'b1;
    drive(HI, 2);
    chk("uv off", 8'h01, {7'h00, spd});
    drive(LO, 3);
    drive(HI, 3);
    chk("uv held", 8'h01, {7'h00, spd});
    drive(LO, 2);
    uv = 1'b0;
    drive(LO, 3);
    drive(HI, 4);
    chk("uv recover", 8'h00, {7'h00, spd});
    chk("falls", 8'h03, falls);
  endtask : t_uv
  task automatic t_reverse();
    rev = 1'b1;
    drive(HI, 4);
    chk("rev tooth", 8'h01, {7'h00, spd});
    drive(LO, 4);
    chk("rev valley", 8'h00, {7'h00, spd});
  endtask : t_reverse
  initial begin
    #100us;
    bad_count++;
    results();
  end
  initial begin
    t_reset();
    t_calib();
    t_switch();
    t_uv();
    t_reverse();
    results();
  end
endmodule : tb_gear_edge_threshold
`default_nettype wire
